// file: inc/rsse_pkg.sv
package rsse_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_INSTR  = 8'h00;
	localparam logic [7:0] ADDR_WREG   = 8'h04;
	localparam logic [7:0] ADDR_BANK   = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_WDT    = 8'h10;
	localparam logic [7:0] ADDR_WAKE   = 8'h14;
	localparam logic [7:0] ADDR_DADDR  = 8'h18;
	localparam logic [7:0] ADDR_DDATA  = 8'h1c;

	// Status and wake field positions
	localparam int STAT_Z    = 0;
	localparam int STAT_N    = 1;
	localparam int STAT_PD   = 2;
	localparam int STAT_TO   = 3;
	localparam int STAT_BUSY = 4;
	localparam int STAT_HALT = 5;
	localparam int WAKE_SW   = 0;

	// Opcode fields
	localparam logic [5:0]  OPC_ROT  = 6'h10;
	localparam logic [6:0]  OPC_SET  = 7'h34;
	localparam logic [15:0] OPC_HALT = 16'h0003;
	localparam int          BIT_D    = 9;
	localparam int          BIT_A    = 8;
	localparam logic        DEST_W   = 1'b0;
	localparam logic        USE_ACC  = 1'b0;

	// Values
	localparam logic [7:0]  ALL_ONES    = 8'hff;
	localparam logic [7:0]  WDT_CLEAR   = 8'h00;
	localparam logic [7:0]  WDT_LAST    = 8'hff;
	localparam logic [7:0]  POST_CLEAR  = 8'h00;
	localparam logic [7:0]  POST_LAST   = 8'hff;
	localparam logic [3:0]  ACCESS_BANK = 4'h0;

	// Reset values
	localparam logic [15:0] INSTR_RST = 16'h0000;
	localparam logic [7:0]  WREG_RST  = 8'h00;
	localparam logic [3:0]  BANK_RST  = 4'h0;
	localparam logic [11:0] DADDR_RST = 12'h000;
	localparam logic        PD_RST    = 1'b1;
	localparam logic        TO_RST    = 1'b1;

	typedef enum {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4, PH_HALT} phase_type;
	typedef enum {OP_NONE, OP_ROT, OP_SET, OP_HALT} op_type;

	// Instruction decode, shared by phases Q1 to Q4
	function automatic op_type decode(input logic [15:0] iw);
		if (iw[15:10] == OPC_ROT)
			return OP_ROT;
		else if (iw[15:9] == OPC_SET)
			return OP_SET;
		else if (iw == OPC_HALT)
			return OP_HALT;
		else
			return OP_NONE;
	endfunction : decode

endpackage : rsse_pkg

// file: verilog/rotate_set_sleep_exec.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps

// Notes on behaviour
// - Rotate right without carry moves every bit down one place, old bit 0 into bit 7, and sets only N and Z.
// - Destination bit 0 sends the rotate result to the working register, 1 back to the file register.
// - Access bit 0 uses the access bank and ignores the bank select register, 1 uses the bank select register.
// - Set-all-ones writes FFh into the addressed file register and leaves every flag alone.
// - The halt instruction clears the power-down status bit and sets the watchdog expiry status bit.
// - The halt instruction loads the watchdog counter with 00h and clears its postscaler.
// - After the halt instruction the core is halted and the main oscillator is stopped.
// - A watchdog time-out that wakes the core from halt clears the watchdog expiry status bit.
module rotate_set_sleep_exec (
	input  wire logic        pclk,     // Core clock
	input  wire logic        presetn,  // Asynchronous reset, active low
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB enable
	input  wire logic        pwrite,   // APB direction
	input  wire logic [7:0]  paddr,    // APB byte address
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error on unmapped address
	output logic             osc_stop  // Main oscillator stopped
);

	rsse_pkg::phase_type phase_r;
	rsse_pkg::phase_type phase_nxt;
	rsse_pkg::op_type    op;
	logic [15:0] instr_r;
	logic [15:0] instr_nxt;
	logic [11:0] eaddr_r;
	logic [11:0] eaddr_nxt;
	logic [7:0]  opnd_r;
	logic [7:0]  opnd_nxt;
	logic [7:0]  result_r;
	logic [7:0]  result_nxt;
	logic [7:0]  wreg_r;
	logic [7:0]  wreg_nxt;
	logic [3:0]  bank_r;
	logic [3:0]  bank_nxt;
	logic        z_r;
	logic        z_nxt;
	logic        n_r;
	logic        n_nxt;
	logic        pd_r;
	logic        pd_nxt;
	logic        to_r;
	logic        to_nxt;
	logic [7:0]  wdt_r;
	logic [7:0]  wdt_nxt;
	logic [7:0]  post_r;
	logic [7:0]  post_nxt;
	logic [11:0] daddr_r;
	logic [11:0] daddr_nxt;
	logic        osc_stop_r;
	logic        osc_stop_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic        mem_we;
	logic [11:0] mem_wa;
	logic [7:0]  mem_wd;
	logic        wr;
	logic        sw_ok;
	logic        wdt_timeout;
	logic [7:0]  mem [0:4095];

	// Bus write strobe and window for software writes
	assign wr    = psel & penable & pready_r & pwrite;
	assign sw_ok = (phase_r == rsse_pkg::PH_IDLE) || (phase_r == rsse_pkg::PH_HALT);
	assign op    = rsse_pkg::decode(instr_r);
	// Watchdog counts on pclk in every phase, so it keeps counting while halted
	assign wdt_timeout = (post_r == rsse_pkg::POST_LAST) && (wdt_r == rsse_pkg::WDT_LAST);

	// Bus answer: data prepared in setup, handed over in a single access cycle
	always_comb
	begin
		pready_nxt  = psel & ~penable;
		pslverr_nxt = 1'b0;
		prdata_nxt  = 32'h0000_0000;
		if (psel && !penable)
		begin
			case (paddr)
				rsse_pkg::ADDR_INSTR:  prdata_nxt = {16'h0000, instr_r};
				rsse_pkg::ADDR_WREG:   prdata_nxt = {24'h00_0000, wreg_r};
				rsse_pkg::ADDR_BANK:   prdata_nxt = {28'h000_0000, bank_r};
				rsse_pkg::ADDR_STATUS:
				begin
					prdata_nxt[rsse_pkg::STAT_Z]    = z_r;
					prdata_nxt[rsse_pkg::STAT_N]    = n_r;
					prdata_nxt[rsse_pkg::STAT_PD]   = pd_r;
					prdata_nxt[rsse_pkg::STAT_TO]   = to_r;
					prdata_nxt[rsse_pkg::STAT_BUSY] = !sw_ok;
					prdata_nxt[rsse_pkg::STAT_HALT] = (phase_r == rsse_pkg::PH_HALT);
				end
				rsse_pkg::ADDR_WDT:    prdata_nxt = {16'h0000, post_r, wdt_r};
				rsse_pkg::ADDR_WAKE:   prdata_nxt = 32'h0000_0000;
				rsse_pkg::ADDR_DADDR:  prdata_nxt = {20'h0_0000, daddr_r};
				rsse_pkg::ADDR_DDATA:  prdata_nxt = {24'h00_0000, mem[daddr_r]};
				default:               pslverr_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Instruction sequencer, flags, watchdog and software-visible state
	always_comb
	begin
		phase_nxt    = phase_r;
		instr_nxt    = instr_r;
		eaddr_nxt    = eaddr_r;
		opnd_nxt     = opnd_r;
		result_nxt   = result_r;
		wreg_nxt     = wreg_r;
		bank_nxt     = bank_r;
		z_nxt        = z_r;
		n_nxt        = n_r;
		pd_nxt       = pd_r;
		to_nxt       = to_r;
		daddr_nxt    = daddr_r;
		osc_stop_nxt = osc_stop_r;
		mem_we       = 1'b0;
		mem_wa       = daddr_r;
		mem_wd       = pwdata[7:0];
		post_nxt     = 8'(post_r + 8'h01);
		wdt_nxt      = (post_r == rsse_pkg::POST_LAST) ? 8'(wdt_r + 8'h01) : wdt_r;

		// Software writes land only while no instruction is in flight
		if (wr && sw_ok)
		begin
			case (paddr)
				rsse_pkg::ADDR_WREG:  wreg_nxt = pwdata[7:0];
				rsse_pkg::ADDR_BANK:  bank_nxt = pwdata[3:0];
				rsse_pkg::ADDR_STATUS:
				begin
					z_nxt = pwdata[rsse_pkg::STAT_Z];
					n_nxt = pwdata[rsse_pkg::STAT_N];
				end
				rsse_pkg::ADDR_DADDR: daddr_nxt = pwdata[11:0];
				rsse_pkg::ADDR_DDATA: mem_we = 1'b1;
				default:              mem_we = 1'b0;
			endcase
		end

		case (phase_r)
			rsse_pkg::PH_IDLE:
			begin
				if (wr && paddr == rsse_pkg::ADDR_INSTR)
				begin
					instr_nxt = pwdata[15:0];
					phase_nxt = rsse_pkg::PH_Q1;
				end
			end
			rsse_pkg::PH_Q1:
			begin
				// Decode and form the file address
				if (instr_r[rsse_pkg::BIT_A] == rsse_pkg::USE_ACC)
					eaddr_nxt = {rsse_pkg::ACCESS_BANK, instr_r[7:0]};
				else
					eaddr_nxt = {bank_r, instr_r[7:0]};
				phase_nxt = (op == rsse_pkg::OP_NONE) ? rsse_pkg::PH_IDLE : rsse_pkg::PH_Q2;
			end
			rsse_pkg::PH_Q2:
			begin
				// Halt does nothing in this phase
				if (op != rsse_pkg::OP_HALT)
					opnd_nxt = mem[eaddr_r];
				phase_nxt = rsse_pkg::PH_Q3;
			end
			rsse_pkg::PH_Q3:
			begin
				if (op == rsse_pkg::OP_ROT)
					result_nxt = {opnd_r[0], opnd_r[7:1]};
				else
					result_nxt = rsse_pkg::ALL_ONES;
				phase_nxt = rsse_pkg::PH_Q4;
			end
			rsse_pkg::PH_Q4:
			begin
				phase_nxt = rsse_pkg::PH_IDLE;
				case (op)
					rsse_pkg::OP_ROT:
					begin
						n_nxt = result_r[7];
						z_nxt = (result_r == 8'h00);
						if (instr_r[rsse_pkg::BIT_D] == rsse_pkg::DEST_W)
							wreg_nxt = result_r;
						else
						begin
							mem_we = 1'b1;
							mem_wa = eaddr_r;
							mem_wd = result_r;
						end
					end
					rsse_pkg::OP_SET:
					begin
						// Flags untouched on purpose
						mem_we = 1'b1;
						mem_wa = eaddr_r;
						mem_wd = result_r;
					end
					rsse_pkg::OP_HALT:
					begin
						pd_nxt       = 1'b0;
						to_nxt       = 1'b1;
						wdt_nxt      = rsse_pkg::WDT_CLEAR;
						post_nxt     = rsse_pkg::POST_CLEAR;
						osc_stop_nxt = 1'b1;
						phase_nxt    = rsse_pkg::PH_HALT;
					end
					default:
					begin
						phase_nxt = rsse_pkg::PH_IDLE;
					end
				endcase
			end
			rsse_pkg::PH_HALT:
			begin
				// Watchdog wake takes priority over a software wake in the same cycle
				if (wdt_timeout)
				begin
					to_nxt       = 1'b0;
					osc_stop_nxt = 1'b0;
					phase_nxt    = rsse_pkg::PH_IDLE;
				end
				else if (wr && paddr == rsse_pkg::ADDR_WAKE && pwdata[rsse_pkg::WAKE_SW])
				begin
					osc_stop_nxt = 1'b0;
					phase_nxt    = rsse_pkg::PH_IDLE;
				end
			end
			default:
			begin
				phase_nxt = rsse_pkg::PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_r    <= rsse_pkg::PH_IDLE;
			instr_r    <= rsse_pkg::INSTR_RST;
			eaddr_r    <= 12'h000;
			opnd_r     <= 8'h00;
			result_r   <= 8'h00;
			wreg_r     <= rsse_pkg::WREG_RST;
			bank_r     <= rsse_pkg::BANK_RST;
			z_r        <= 1'b0;
			n_r        <= 1'b0;
			pd_r       <= rsse_pkg::PD_RST;
			to_r       <= rsse_pkg::TO_RST;
			wdt_r      <= rsse_pkg::WDT_CLEAR;
			post_r     <= rsse_pkg::POST_CLEAR;
			daddr_r    <= rsse_pkg::DADDR_RST;
			osc_stop_r <= 1'b0;
		end
		else
		begin
			phase_r    <= phase_nxt;
			instr_r    <= instr_nxt;
			eaddr_r    <= eaddr_nxt;
			opnd_r     <= opnd_nxt;
			result_r   <= result_nxt;
			wreg_r     <= wreg_nxt;
			bank_r     <= bank_nxt;
			z_r        <= z_nxt;
			n_r        <= n_nxt;
			pd_r       <= pd_nxt;
			to_r       <= to_nxt;
			wdt_r      <= wdt_nxt;
			post_r     <= post_nxt;
			daddr_r    <= daddr_nxt;
			osc_stop_r <= osc_stop_nxt;
		end
	end

	// Data memory has no reset; software must initialise what it reads
	always_ff @(posedge pclk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
	assign osc_stop = osc_stop_r;

endmodule : rotate_set_sleep_exec

// file: tb/rsse_checker.sv
`timescale 1ns/10ps

// Watches the APB side and the halt output of the decoder
module rsse_checker (
	input wire logic        pclk,    // Core clock
	input wire logic        presetn, // Reset, active low
	input wire logic        psel,    // APB select
	input wire logic        penable, // APB enable
	input wire logic        pwrite,  // APB direction
	input wire logic [7:0]  paddr,   // APB address
	input wire logic [31:0] pwdata,  // APB write data
	input wire logic [31:0] prdata,  // APB read data
	input wire logic        pready,  // APB ready
	input wire logic        pslverr, // APB error
	input wire logic        osc_stop // Oscillator stopped
);
	logic acc;
	logic halt_wr;
	logic wake_wr;

	// A halt only counts while running; the bench never sends one while busy
	assign acc = psel && penable && pready;
	assign halt_wr = acc && pwrite && paddr == rsse_pkg::ADDR_INSTR && pwdata[15:0] == rsse_pkg::OPC_HALT && !osc_stop;
	assign wake_wr = acc && pwrite && paddr == rsse_pkg::ADDR_WAKE && pwdata[rsse_pkg::WAKE_SW] && osc_stop;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_after_setup : assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	a_ready_in_access : assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_ready_one_cycle : assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_unmapped : assert property (acc && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_ok_mapped : assert property (acc && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	// Four phases after the accepted write, then the oscillator stops on the next edge
	a_halt_stops_osc : assert property (halt_wr |=> !osc_stop [*4] ##1 osc_stop)
		else $error("halt timing wrong");
	a_halt_status : assert property (acc && !pwrite && paddr == rsse_pkg::ADDR_STATUS && osc_stop
		|-> !prdata[rsse_pkg::STAT_PD] && prdata[rsse_pkg::STAT_HALT])
		else $error("status wrong while halted");
	a_wake_runs : assert property (wake_wr |=> !osc_stop)
		else $error("wake ignored");

	c_halt : cover property (halt_wr);
	c_wake : cover property (wake_wr);
	c_err : cover property (acc && pslverr);
	c_osc_fall : cover property ($fell(osc_stop));
endmodule : rsse_checker

bind rotate_set_sleep_exec rsse_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.osc_stop(osc_stop));

// file: tb/fetch_stage_model.sv
`timescale 1ns/10ps

// Fetch side: issues one APB transfer at a time
module fetch_stage_model (
	input  wire logic        pclk,    // Core clock
	output logic             psel,    // Select
	output logic             penable, // Enable
	output logic             pwrite,  // Direction
	output logic [7:0]       paddr,   // Address
	output logic [31:0]      pwdata,  // Write data
	input  wire logic [31:0] prdata,  // Read data
	input  wire logic        pready,  // Ready
	input  wire logic        pslverr  // Error
);
	// Idle bus at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// Address and write data are inverted on release so a stale value cannot pass for live data
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic tmo);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		tmo = (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : fetch_stage_model

// file: tb/testbench.sv
`timescale 1ns/10ps

module testbench;
	typedef struct {logic [15:0] iw; logic [3:0] bank; logic [11:0] fa; logic [7:0] init;
		logic [7:0] exp; logic to_w; logic [1:0] fin; logic [1:0] fexp;} row_type;
	logic        pclk;
	logic        presetn;
	logic        psel, penable, pwrite, pready, pslverr, osc_stop, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          fails, checked;
	// Word, bank, file address, start, result, to working reg, flags before, flags after {N,Z}
	row_type rows [6] = '{
		'{16'h4220, 4'h7, 12'h020, 8'hd7, 8'heb, 1'b0, 2'b00, 2'b10},
		'{16'h4021, 4'h7, 12'h021, 8'hd7, 8'heb, 1'b1, 2'b01, 2'b10},
		'{16'h4305, 4'h3, 12'h305, 8'h01, 8'h80, 1'b0, 2'b00, 2'b10},
		'{16'h4200, 4'h0, 12'h000, 8'h00, 8'h00, 1'b0, 2'b10, 2'b01},
		'{16'h6910, 4'h2, 12'h210, 8'h5a, 8'hff, 1'b0, 2'b11, 2'b11},
		'{16'h68ff, 4'h5, 12'h0ff, 8'h00, 8'hff, 1'b0, 2'b01, 2'b01}};

	rotate_set_sleep_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_stop(osc_stop));
	fetch_stage_model u_fetch (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 100 ns clock
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	// A hung transfer ends the run
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic tmo;
		u_fetch.xfer(w, a, d, rd, err, tmo);
		if (tmo)
		begin
			fails++;
			print_verdict();
		end
	endtask : bus

	task automatic wait_osc(input logic lvl, input int lim);
		int n;
		n = 0;
		while (osc_stop !== lvl && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		check("osc_stop", lvl, osc_stop);
		if (osc_stop !== lvl)
			print_verdict();
	endtask : wait_osc

	// Main sequence: reset values first, then table rows, refusal and halt cases, then reset while halted
	initial
	begin
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		bus(0, rsse_pkg::ADDR_STATUS, 0);
		check("status rst", 32'h0c, rd);
		bus(0, rsse_pkg::ADDR_WREG, 0);
		check("wreg rst", 32'h0, rd);
		foreach (rows[i])
		begin
			bus(1, rsse_pkg::ADDR_BANK, rows[i].bank);
			bus(1, rsse_pkg::ADDR_DADDR, rows[i].fa);
			bus(1, rsse_pkg::ADDR_DDATA, rows[i].init);
			bus(1, rsse_pkg::ADDR_WREG, 32'h33);
			bus(1, rsse_pkg::ADDR_STATUS, rows[i].fin);
			bus(1, rsse_pkg::ADDR_INSTR, rows[i].iw);
			bus(0, rsse_pkg::ADDR_STATUS, 0);
			check("busy", 1'b1, rd[rsse_pkg::STAT_BUSY]);
			bus(0, rsse_pkg::ADDR_STATUS, 0);
			check("flags", {26'h0, 4'h3, rows[i].fexp}, rd);
			bus(0, rsse_pkg::ADDR_DDATA, 0);
			check("file reg", rows[i].to_w ? rows[i].init : rows[i].exp, rd);
			bus(0, rsse_pkg::ADDR_WREG, 0);
			check("wreg", rows[i].to_w ? rows[i].exp : 8'h33, rd);
		end
		// Unknown opcode must leave flags and working register alone
		bus(1, rsse_pkg::ADDR_INSTR, 32'h0000_0001);
		bus(0, rsse_pkg::ADDR_STATUS, 0);
		check("unknown op status", 32'h0000_000d, rd);
		bus(0, rsse_pkg::ADDR_WREG, 0);
		check("unknown op wreg", 32'h0000_0033, rd);
		bus(0, 8'h20, 0);
		check("unmapped err", 32'h0000_0001, {31'h0, err});
		check("unmapped data", 32'h0000_0000, rd);
		bus(1, rsse_pkg::ADDR_INSTR, rsse_pkg::OPC_HALT);
		wait_osc(1'b1, 10);
		bus(0, rsse_pkg::ADDR_STATUS, 0);
		check("halt status", 4'ha, rd[5:2]);
		bus(0, rsse_pkg::ADDR_WDT, 0);
		check("wdt", 9'h100, {rd[15:8] < 8'h10, rd[7:0]});
		bus(1, rsse_pkg::ADDR_WAKE, 1);
		wait_osc(1'b0, 3);
		bus(0, rsse_pkg::ADDR_STATUS, 0);
		check("woken status", 4'h2, rd[5:2]);
		bus(1, rsse_pkg::ADDR_INSTR, rsse_pkg::OPC_HALT);
		wait_osc(1'b1, 10);
		wait_osc(1'b0, 70000);
		bus(0, rsse_pkg::ADDR_STATUS, 0);
		check("timeout status", 4'h0, rd[5:2]);
		// Reset while halted must restart the oscillator and restore both status bits
		bus(1, rsse_pkg::ADDR_INSTR, rsse_pkg::OPC_HALT);
		wait_osc(1'b1, 10);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("osc_stop mid rst", 32'h0, osc_stop);
		presetn <= 1'b1;
		bus(0, rsse_pkg::ADDR_STATUS, 0);
		check("status mid rst", 32'h0c, rd);
		print_verdict();
	end
endmodule : testbench
